// File: timer_ctrl_pkg.sv
// Package of register map, field positions and reset values for the timer control block
// Contract
// - Channel 7 compare copies masked data bits to pins
// - Main counter is 16-bit, counts up only
// - Counter writes only accepted in test mode
// - First period after counter write may vary
// - Timer enable low stops counter, prescaler and ticks; forced compares and flags still act
// - No divide-by-64 tick while timer inactive
// - Stop-in-wait halts timer and accumulator tick
// - Stop-in-freeze halts counter, accumulator keeps running
// - Fast clear: capture read/compare write clears flag
// - Fast clear: counter access clears overflow flag
// - Fast clear: accumulator access clears both flags
// - Without fast clear, only write-one clears flags
// - Overflow toggle inverts enabled compare pins
// - Toggle beats force, yields to channel 7
// - Mode/level pair selects pin action
// - Nonzero mode or level makes pin output
// - Masked pin follows channel 7 data bit
// - Overflow flag set on all-ones to zero wrap
package timer_ctrl_pkg;
  // Register indices; each register takes one word at four times its index
  localparam int IDX_DIRECTION    = 8'h00;
  localparam int IDX_FORCE        = 8'h01;
  localparam int IDX_MASK7        = 8'h02;
  localparam int IDX_DATA7        = 8'h03;
  localparam int IDX_COUNTER      = 8'h04;
  localparam int IDX_SYS_CONTROL  = 8'h06;
  localparam int IDX_TOGGLE       = 8'h07;
  localparam int IDX_OUT_CONTROL  = 8'h08;
  localparam int IDX_PRESCALE     = 8'h0D;
  localparam int IDX_CHAN_FLAGS   = 8'h0E;
  localparam int IDX_OVF_FLAGS    = 8'h0F;
  localparam int IDX_COMPARE4     = 8'h18;
  localparam int IDX_ACCUM_FLAGS  = 8'h21;
  localparam int IDX_ACCUM_COUNT  = 8'h22;
  // Compare channels are 16-bit, so each spans two indices
  localparam int COMPARE_IDX_STEP = 2;
  // Byte addresses of the registers
  localparam logic [11:0] ADDR_DIRECTION     = 12'(4 * IDX_DIRECTION);
  localparam logic [11:0] ADDR_FORCE         = 12'(4 * IDX_FORCE);
  localparam logic [11:0] ADDR_MASK7         = 12'(4 * IDX_MASK7);
  localparam logic [11:0] ADDR_DATA7         = 12'(4 * IDX_DATA7);
  localparam logic [11:0] ADDR_COUNTER       = 12'(4 * IDX_COUNTER);
  localparam logic [11:0] ADDR_SYS_CONTROL   = 12'(4 * IDX_SYS_CONTROL);
  localparam logic [11:0] ADDR_TOGGLE        = 12'(4 * IDX_TOGGLE);
  localparam logic [11:0] ADDR_OUT_CONTROL   = 12'(4 * IDX_OUT_CONTROL);
  localparam logic [11:0] ADDR_PRESCALE      = 12'(4 * IDX_PRESCALE);
  localparam logic [11:0] ADDR_CHAN_FLAGS    = 12'(4 * IDX_CHAN_FLAGS);
  localparam logic [11:0] ADDR_OVF_FLAGS     = 12'(4 * IDX_OVF_FLAGS);
  localparam logic [11:0] ADDR_COMPARE4      = 12'(4 * IDX_COMPARE4);
  localparam logic [11:0] ADDR_ACCUM_FLAGS   = 12'(4 * IDX_ACCUM_FLAGS);
  localparam logic [11:0] ADDR_ACCUM_COUNT   = 12'(4 * IDX_ACCUM_COUNT);
  // Field positions in system control one
  localparam int ENABLE_BIT = 7;
  localparam int SWAI_BIT  = 6;
  localparam int SFRZ_BIT  = 5;
  localparam int FFCA_BIT  = 4;
  // Overflow flag position
  localparam int OVF_FLAG_BIT   = 7;
  // Accumulator flag positions
  localparam int ACCUM_OVF_POS  = 1;
  localparam int ACCUM_EDGE_POS = 0;
  // Reset values
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [15:0] RESET_COUNT   = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONE = 16'hFFFF;
  // Accumulator tick divider
  localparam int ACCUM_DIV = 64;
  // Pin action encodings of a mode/level pair
  localparam logic [1:0] ACT_DISCONNECT = 2'h0;
  localparam logic [1:0] ACT_TOGGLE     = 2'h1;
  localparam logic [1:0] ACT_CLEAR      = 2'h2;
  localparam logic [1:0] ACT_SET        = 2'h3;
endpackage

// File: timer_ctrl.sv
// Timer control: counter, system control bits, compare pin output logic
//
// Implementation choice: the APB slave port.
module timer_ctrl #(
  parameter int CHANNELS = 4  // Channels 7..4
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip mode inputs
  input  wire logic        test_mode,
  input  wire logic        wait_mode,
  input  wire logic        freeze_mode,
  // Compare events per channel (bit 3 is channel 7)
  input  wire logic [3:0]  compare_hit,
  input  wire logic [3:0]  capture_hit,
  // Accumulator events from its own logic
  input  wire logic        accum_overflow_evt,
  input  wire logic        accum_edge_evt,
  // Pins and ticks
  output logic [3:0]       compare_output_line,
  output logic [3:0]       pin_output_enable,
  output logic             accum_tick,
  output logic             timer_wake_enable,
  output logic [15:0]      main_counter_out
);
  // Software visible registers
  logic [3:0]  channel_direction_select; // 1 = output compare
  logic [3:0]  compare7_mask;
  logic [3:0]  compare7_data;
  logic [15:0] main_counter;
  logic [7:0]  system_control_one;
  logic [3:0]  overflow_toggle_reg;
  logic [7:0]  compare_output_control;
  logic [2:0]  prescale_sel;
  logic [3:0]  channel_flag_reg;
  logic        overflow_flag;
  logic [1:0]  accum_flag_reg;
  // Prescaler state
  logic [6:0]  prescale_cnt;
  logic [5:0]  accum_div_cnt;
  // Decoded bus strobes
  logic        access;
  logic        wr;
  logic        rd;
  logic [3:0]  force_req;
  logic        mapped;
  // Control decode
  logic        timer_run;
  logic        counter_run;
  logic        tick;
  logic        overflow_evt;
  logic [3:0]  pin_drive;
  logic [3:0]  next_pins;
  logic [7:0]  next_rdata;

  // Transfers complete in the access cycle with no wait states
  assign access = psel & penable & clk_en;
  assign wr     = access & pwrite;
  assign rd     = access & ~pwrite;
  assign force_req = (wr && paddr == timer_ctrl_pkg::ADDR_FORCE) ? pwdata[7:4] : 4'h0;

  // Module runs only when enabled and not parked in wait
  assign timer_run   = system_control_one[timer_ctrl_pkg::ENABLE_BIT] &
                       ~(system_control_one[timer_ctrl_pkg::SWAI_BIT] & wait_mode);
  // Freeze halts the counter only
  assign counter_run = timer_run &
                       ~(system_control_one[timer_ctrl_pkg::SFRZ_BIT] & freeze_mode);

  // Prescaled tick: all selected low stages at zero
  always_comb begin
    tick = 1'b0;
    case (prescale_sel)
      3'h0:    tick = 1'b1;
      default: tick = (prescale_cnt & ((7'h01 << prescale_sel) - 7'h01)) == 7'h00;
    endcase
  end

  assign overflow_evt = counter_run & tick & (main_counter == timer_ctrl_pkg::COUNT_ALL_ONE);

  // Free-running prescale counter; counter writes do not realign it, so the
  // first period after a write may be shorter than a full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_cnt <= 7'h00;
    end else if (clk_en && timer_run) begin
      prescale_cnt <= prescale_cnt + 7'h01;
    end
  end

  // Divide-by-64 tick for the accumulator, counting every enabled clock while the timer runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_div_cnt <= 6'h00;
      accum_tick    <= 1'b0;
    end else if (clk_en) begin
      if (timer_run) begin
        accum_div_cnt <= accum_div_cnt + 6'h01;
        accum_tick    <= (accum_div_cnt == 6'(timer_ctrl_pkg::ACCUM_DIV - 1));
      end else begin
        accum_tick    <= 1'b0;
      end
    end
  end

  // Main counter: up only, software write only in test mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_counter <= timer_ctrl_pkg::RESET_COUNT;
    end else if (clk_en) begin
      if (wr && paddr == timer_ctrl_pkg::ADDR_COUNTER && test_mode) begin
        main_counter <= pwdata[15:0];
      end else if (counter_run && tick) begin
        main_counter <= main_counter + 16'h0001;
      end
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_direction_select <= 4'h0;
      compare7_mask            <= 4'h0;
      compare7_data            <= 4'h0;
      system_control_one       <= timer_ctrl_pkg::RESET_BYTE;
      overflow_toggle_reg      <= 4'h0;
      compare_output_control   <= timer_ctrl_pkg::RESET_BYTE;
      prescale_sel             <= 3'h0;
    end else if (wr) begin
      case (paddr)
        timer_ctrl_pkg::ADDR_DIRECTION:   channel_direction_select <= pwdata[7:4];
        timer_ctrl_pkg::ADDR_MASK7:       compare7_mask            <= pwdata[7:4];
        timer_ctrl_pkg::ADDR_DATA7:       compare7_data            <= pwdata[7:4];
        // Low nibble reserved
        timer_ctrl_pkg::ADDR_SYS_CONTROL: system_control_one       <= {pwdata[7:4], 4'h0};
        timer_ctrl_pkg::ADDR_TOGGLE:      overflow_toggle_reg      <= pwdata[7:4];
        timer_ctrl_pkg::ADDR_OUT_CONTROL: compare_output_control   <= pwdata[7:0];
        timer_ctrl_pkg::ADDR_PRESCALE:    prescale_sel             <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Channel flags: set wins over every clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_flag_reg <= 4'h0;
    end else if (clk_en) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if ((compare_hit[i] && channel_direction_select[i] && !force_req[i]) ||
            (capture_hit[i] && !channel_direction_select[i])) begin
          channel_flag_reg[i] <= 1'b1;
        end else if (wr && paddr == timer_ctrl_pkg::ADDR_CHAN_FLAGS && pwdata[4 + i]) begin
          channel_flag_reg[i] <= 1'b0;
        end else if (system_control_one[timer_ctrl_pkg::FFCA_BIT] &&
                     paddr == timer_ctrl_pkg::ADDR_COMPARE4 +
                              12'(4 * timer_ctrl_pkg::COMPARE_IDX_STEP * i) &&
                     ((rd && !channel_direction_select[i]) ||
                      (wr && channel_direction_select[i]))) begin
          channel_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Overflow flag: set on wrap, cleared by write-one or fast clear access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (clk_en) begin
      if (overflow_evt) begin
        overflow_flag <= 1'b1;
      end else if (wr && paddr == timer_ctrl_pkg::ADDR_OVF_FLAGS &&
                   pwdata[timer_ctrl_pkg::OVF_FLAG_BIT]) begin
        overflow_flag <= 1'b0;
      end else if (access && paddr == timer_ctrl_pkg::ADDR_COUNTER &&
                   system_control_one[timer_ctrl_pkg::FFCA_BIT]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // Accumulator flags held here for the fast clear path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_flag_reg <= 2'h0;
    end else if (clk_en) begin
      if (access && paddr == timer_ctrl_pkg::ADDR_ACCUM_COUNT &&
          system_control_one[timer_ctrl_pkg::FFCA_BIT]) begin
        accum_flag_reg <= {accum_overflow_evt, accum_edge_evt};
      end else if (wr && paddr == timer_ctrl_pkg::ADDR_ACCUM_FLAGS) begin
        // Write one clears, a coincident event still sets
        accum_flag_reg <= (accum_flag_reg & ~pwdata[1:0]) |
                          {accum_overflow_evt, accum_edge_evt};
      end else begin
        accum_flag_reg <= accum_flag_reg | {accum_overflow_evt, accum_edge_evt};
      end
    end
  end

  // Pin action per channel: channel 7 override, then toggle, then force/own compare
  always_comb begin
    next_pins = compare_output_line;
    for (int i = 0; i < CHANNELS; i++) begin
      if (channel_direction_select[i]) begin
        if (compare_hit[3] && channel_direction_select[3] && compare7_mask[i] && timer_run) begin
          next_pins[i] = compare7_data[i];
        end else if (overflow_evt && overflow_toggle_reg[i]) begin
          next_pins[i] = ~compare_output_line[i];
        end else if (force_req[i] || (compare_hit[i] && timer_run)) begin
          case (compare_output_control[2 * i +: 2])
            timer_ctrl_pkg::ACT_TOGGLE: next_pins[i] = ~compare_output_line[i];
            timer_ctrl_pkg::ACT_CLEAR:  next_pins[i] = 1'b0;
            timer_ctrl_pkg::ACT_SET:    next_pins[i] = 1'b1;
            default:                    next_pins[i] = compare_output_line[i];
          endcase
        end
      end
    end
  end

  // Pin drive: mode or level set, or masked by channel 7 on an output compare
  always_comb begin
    pin_drive = 4'h0;
    for (int i = 0; i < CHANNELS; i++) begin
      pin_drive[i] = (|compare_output_control[2 * i +: 2]) |
                     (compare7_mask[i] & channel_direction_select[i]);
    end
  end

  // Output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_line <= 4'h0;
      pin_output_enable   <= 4'h0;
      timer_wake_enable   <= 1'b0;
      main_counter_out    <= timer_ctrl_pkg::RESET_COUNT;
    end else if (clk_en) begin
      compare_output_line <= next_pins;
      pin_output_enable   <= pin_drive;
      // Wait-stopped timer cannot wake the processor
      timer_wake_enable   <= ~system_control_one[timer_ctrl_pkg::SWAI_BIT];
      main_counter_out    <= main_counter;
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 8'h00;
    mapped     = 1'b1;
    case (paddr)
      timer_ctrl_pkg::ADDR_DIRECTION:   next_rdata = {channel_direction_select, 4'h0};
      timer_ctrl_pkg::ADDR_FORCE:       next_rdata = 8'h00;
      timer_ctrl_pkg::ADDR_MASK7:       next_rdata = {compare7_mask, 4'h0};
      timer_ctrl_pkg::ADDR_DATA7:       next_rdata = {compare7_data, 4'h0};
      timer_ctrl_pkg::ADDR_COUNTER:     next_rdata = 8'h00;
      timer_ctrl_pkg::ADDR_SYS_CONTROL: next_rdata = system_control_one;
      timer_ctrl_pkg::ADDR_TOGGLE:      next_rdata = {overflow_toggle_reg, 4'h0};
      timer_ctrl_pkg::ADDR_OUT_CONTROL: next_rdata = compare_output_control;
      timer_ctrl_pkg::ADDR_PRESCALE:    next_rdata = {5'h00, prescale_sel};
      timer_ctrl_pkg::ADDR_CHAN_FLAGS:  next_rdata = {channel_flag_reg, 4'h0};
      timer_ctrl_pkg::ADDR_OVF_FLAGS:   next_rdata = {overflow_flag, 7'h00};
      timer_ctrl_pkg::ADDR_ACCUM_FLAGS: next_rdata = {6'h00, accum_flag_reg};
      timer_ctrl_pkg::ADDR_ACCUM_COUNT: next_rdata = 8'h00;
      default:                          mapped     = 1'b0;
    endcase
  end

  // APB answer: registered, no wait states; whole word counter read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      // Bus answer freezes with the rest of the block
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= (paddr == timer_ctrl_pkg::ADDR_COUNTER) ?
                  {16'h0000, main_counter} : {24'h00_0000, next_rdata};
      end
    end
  end
endmodule // timer_ctrl

// File: timer_ctrl_assertions.sv
// Port checker of the timer control block, bound onto its top module
module timer_ctrl_assertions #(
  parameter int CHANNELS = 4  // Channels 7..4
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Chip modes and events
  input wire logic        test_mode,
  input wire logic        wait_mode,
  input wire logic        freeze_mode,
  input wire logic [3:0]  compare_hit,
  input wire logic [3:0]  capture_hit,
  input wire logic        accum_overflow_evt,
  input wire logic        accum_edge_evt,
  // Pins and ticks
  input wire logic [3:0]  compare_output_line,
  input wire logic [3:0]  pin_output_enable,
  input wire logic        accum_tick,
  input wire logic        timer_wake_enable,
  input wire logic [15:0] main_counter_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] ctl;   // Enable, wait stop, freeze stop, fast clear
  logic [3:0] mask;  // Channel 7 mask copy
  logic [3:0] data;  // Channel 7 data copy
  logic [7:0] outc;  // Mode/level pairs copy
  logic [6:0] gap;   // Cycles since last accumulator tick
  logic       wr;    // Completed write
  logic       run;   // Prescaler allowed to run
  logic [3:0] want;  // Pairs asking for a driven pin
  assign wr   = psel && penable && pready && pwrite && clk_en;
  assign run  = ctl[3] && clk_en && !(ctl[2] && wait_mode);
  assign want = {|outc[7:6], |outc[5:4], |outc[3:2], |outc[1:0]};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow copies follow completed writes, as the block does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ctl, mask, data, outc} <= 20'h00000;
    end else if (wr) begin
      case (paddr)
        timer_ctrl_pkg::ADDR_SYS_CONTROL: ctl <= pwdata[7:4];
        timer_ctrl_pkg::ADDR_MASK7:       mask <= pwdata[7:4];
        timer_ctrl_pkg::ADDR_DATA7:       data <= pwdata[7:4];
        timer_ctrl_pkg::ADDR_OUT_CONTROL: outc <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  // Tick spacing; restarts whenever the prescaler is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 7'h00;
    end else if (accum_tick || !run) begin
      gap <= 7'h00;
    end else if (gap != 7'h7F) begin
      gap <= gap + 7'h01;
    end
  end
  property p_count_up;
    !test_mode && !$past(test_mode) && !$past(test_mode, 2) |->
      16'(main_counter_out - $past(main_counter_out)) <= 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter stepped wrongly");
  property p_hold_off;
    // Counter copy lags one cycle, so a test write shows two cycles later
    !ctl[3] && !$past(ctl[3]) && !test_mode && !$past(test_mode) && !$past(test_mode, 2) |->
      $stable(main_counter_out);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("counter ran while disabled");
  property p_no_tick;
    !ctl[3] && !$past(ctl[3]) && !$past(ctl[3], 2) |-> !accum_tick;
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("accumulator tick while off");
  property p_tick_gap;
    run |-> gap < 7'h44;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("accumulator tick missing");
  property p_wait_halt;
    (ctl[2] && wait_mode) [*3] |-> $stable(main_counter_out) && !accum_tick && !timer_wake_enable;
  endproperty
  a_wait_halt: assert property (p_wait_halt) else $error("timer ran in wait");
  property p_freeze_halt;
    (ctl[1] && freeze_mode) [*3] |-> $stable(main_counter_out);
  endproperty
  a_freeze_halt: assert property (p_freeze_halt) else $error("counter ran in freeze");
  property p_ch7_copy;
    compare_hit[3] && ctl[3] && clk_en |=>
      ((compare_output_line ^ $past(data)) & $past(mask)) == 4'h0;
  endproperty
  a_ch7_copy: assert property (p_ch7_copy) else $error("masked pin missed data");
  property p_pin_drive;
    $stable(want) |-> (want & ~pin_output_enable) == 4'h0;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");
  c_ch7: cover property (compare_hit[3] && mask != 4'h0);
  c_wait: cover property (ctl[2] && wait_mode);
  c_frz: cover property (accum_tick && freeze_mode);
endmodule  // timer_ctrl_assertions

bind timer_ctrl timer_ctrl_assertions #(.CHANNELS(CHANNELS)) u_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .test_mode(test_mode), .wait_mode(wait_mode),
  .freeze_mode(freeze_mode), .compare_hit(compare_hit), .capture_hit(capture_hit),
  .accum_overflow_evt(accum_overflow_evt), .accum_edge_evt(accum_edge_evt),
  .compare_output_line(compare_output_line), .pin_output_enable(pin_output_enable),
  .accum_tick(accum_tick), .timer_wake_enable(timer_wake_enable),
  .main_counter_out(main_counter_out)
);

// File: timer_pins_model.sv
// Port side model: event sources toward the block and pin wires
module timer_pins_model (
  // Clock
  input  wire logic       pclk,
  // Events toward the block
  output logic      [3:0] compare_hit,
  output logic      [3:0] capture_hit,
  output logic            accum_overflow_evt,
  output logic            accum_edge_evt,
  // Pins
  input  wire logic [3:0] compare_output_line,
  input  wire logic [3:0] pin_output_enable,
  output wire logic [3:0] pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released pins rise to the pull-up, never the last value
  assign pin_level = (compare_output_line & pin_output_enable) | ~pin_output_enable;
  // Quiet until asked
  initial begin
    compare_hit = 4'h0;
    capture_hit = 4'h0;
    {accum_overflow_evt, accum_edge_evt} = 2'h0;
  end
  // One-cycle events, launched just after an edge
  task automatic pulse(input logic [3:0] hit, input logic [1:0] acc);
    @(posedge pclk);
    compare_hit <= hit;
    {accum_overflow_evt, accum_edge_evt} <= acc;
    @(posedge pclk);
    compare_hit <= 4'h0;
    {accum_overflow_evt, accum_edge_evt} <= 2'h0;
  endtask
endmodule  // timer_pins_model

// File: timer_counter_control_outputs_test.sv
// Self-checking bench of the timer control block
module timer_counter_control_outputs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        test_mode = 1'b0, wait_mode = 1'b0, freeze_mode = 1'b0;
  logic [11:0] paddr = 12'h000;     // Bus address
  logic [31:0] pwdata = 32'h0, prdata, rd, a;  // Bus data, last read, saved read
  logic        pready, pslverr, tick, wake;     // Block answers
  logic [3:0]  hit, cap, line, oe, pin;         // Events and pins
  logic [1:0]  acc;                             // Accumulator events
  logic [15:0] cnt;                             // Counter copy
  int          fails, checks_done, cyc, t;      // Tallies and cycle clock
  localparam logic [3:0] pin_exp = 4'hD;        // Pin per mode step
  always #2 pclk = ~pclk;
  timer_ctrl u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .test_mode(test_mode), .wait_mode(wait_mode),
    .freeze_mode(freeze_mode), .compare_hit(hit), .capture_hit(cap),
    .accum_overflow_evt(acc[1]), .accum_edge_evt(acc[0]), .compare_output_line(line),
    .pin_output_enable(oe), .accum_tick(tick), .timer_wake_enable(wake),
    .main_counter_out(cnt));
  timer_pins_model u_pins (.pclk(pclk), .compare_hit(hit), .capture_hit(cap),
    .accum_overflow_evt(acc[1]), .accum_edge_evt(acc[0]), .compare_output_line(line),
    .pin_output_enable(oe), .pin_level(pin));
  // Compare and tally
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Report and stop
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare
  task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(timer_ctrl_pkg::ADDR_SYS_CONTROL, 32'h0);
    rdc(timer_ctrl_pkg::ADDR_TOGGLE, 32'h0);
    rdc(12'hFFC, 32'h0);
    chk(32'(pslverr), 32'h1);
    apb(1'b1, timer_ctrl_pkg::ADDR_COUNTER, 32'h1234);  // Ignored outside test mode
    rdc(timer_ctrl_pkg::ADDR_COUNTER, 32'h0);
    test_mode <= 1'b1;
    apb(1'b1, timer_ctrl_pkg::ADDR_COUNTER, 32'hFFF0);
    test_mode <= 1'b0;
    rdc(timer_ctrl_pkg::ADDR_COUNTER, 32'hFFF0);
    apb(1'b1, timer_ctrl_pkg::ADDR_DIRECTION, 32'hF0);
    apb(1'b1, timer_ctrl_pkg::ADDR_TOGGLE, 32'h90);
    apb(1'b1, timer_ctrl_pkg::ADDR_SYS_CONTROL, 32'h80);
    repeat (30) @(posedge pclk);
    chk(32'(line), 32'h9);
    rdc(timer_ctrl_pkg::ADDR_OVF_FLAGS, 32'h80);
    apb(1'b0, timer_ctrl_pkg::ADDR_COUNTER, 32'h0);
    {a, t} = {rd, cyc};
    apb(1'b0, timer_ctrl_pkg::ADDR_COUNTER, 32'h0);
    chk(rd - a, 32'(cyc - t));
    rdc(timer_ctrl_pkg::ADDR_OVF_FLAGS, 32'h80);
    apb(1'b1, timer_ctrl_pkg::ADDR_SYS_CONTROL, 32'h90);
    apb(1'b0, timer_ctrl_pkg::ADDR_COUNTER, 32'h0);
    rdc(timer_ctrl_pkg::ADDR_OVF_FLAGS, 32'h0);
    // Channel 6 through set, clear, toggle, disconnect
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, timer_ctrl_pkg::ADDR_OUT_CONTROL, {26'h0, 2'(3 - i), 4'h0});
      u_pins.pulse(4'h4, 2'h0);
      @(negedge pclk);
      chk(32'(pin[2]), 32'(pin_exp[i]));
      chk(32'(oe[2]), 32'(i < 3));
    end
    apb(1'b1, timer_ctrl_pkg::ADDR_OUT_CONTROL, 32'h30);
    apb(1'b1, timer_ctrl_pkg::ADDR_MASK7, 32'h60);
    apb(1'b1, timer_ctrl_pkg::ADDR_DATA7, 32'h20);
    u_pins.pulse(4'hC, 2'h0);
    @(negedge pclk);
    chk(32'(line), 32'hB);
    chk(32'(oe & 4'h9), 32'h0);
    // Forced compare on channel 6 applies its set action
    apb(1'b1, timer_ctrl_pkg::ADDR_FORCE, 32'h40);
    @(negedge pclk);
    chk(32'(line), 32'hF);
    for (int f = 1; f >= 0; f--) begin
      apb(1'b1, timer_ctrl_pkg::ADDR_CHAN_FLAGS, 32'hF0);
      apb(1'b1, timer_ctrl_pkg::ADDR_ACCUM_FLAGS, 32'h3);
      apb(1'b1, timer_ctrl_pkg::ADDR_SYS_CONTROL, f ? 32'h90 : 32'h80);
      u_pins.pulse(4'h2, 2'h3);
      rdc(timer_ctrl_pkg::ADDR_CHAN_FLAGS, 32'h20);
      apb(1'b1, timer_ctrl_pkg::ADDR_COMPARE4 + 12'h008, 32'h0);
      apb(1'b0, timer_ctrl_pkg::ADDR_ACCUM_COUNT, 32'h0);
      rdc(timer_ctrl_pkg::ADDR_CHAN_FLAGS, f ? 32'h0 : 32'h20);
      rdc(timer_ctrl_pkg::ADDR_ACCUM_FLAGS, f ? 32'h0 : 32'h3);
    end
    // Divide by 8: any 64 cycles hold exactly 8 ticks
    apb(1'b1, timer_ctrl_pkg::ADDR_PRESCALE, 32'h3);
    apb(1'b0, timer_ctrl_pkg::ADDR_COUNTER, 32'h0);
    a = rd;
    repeat (61) @(posedge pclk);
    apb(1'b0, timer_ctrl_pkg::ADDR_COUNTER, 32'h0);
    chk(rd - a, 32'h8);
    apb(1'b1, timer_ctrl_pkg::ADDR_SYS_CONTROL, 32'hE0);
    for (int m = 0; m < 2; m++) begin
      {wait_mode, freeze_mode} <= m ? 2'h1 : 2'h2;
      repeat (4) @(posedge pclk);
      apb(1'b0, timer_ctrl_pkg::ADDR_COUNTER, 32'h0);
      a = rd;
      repeat (150) @(posedge pclk);
      rdc(timer_ctrl_pkg::ADDR_COUNTER, a);
      chk(32'(cnt), a);
      chk(32'(wake), 32'h0);
    end
    end_sim();
  end
endmodule  // timer_counter_control_outputs_test
